// File: rtl/bel_top.v
// BCH error locator: root search engine, registers and remainder access
`timescale 1ns/1ns
`include "bel_map.vh"

module bel_top (
    input wire clock,
    input wire arst_n,
    input wire [11:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    output wire [31:0] bus_rdata,
    output reg irq,
    input wire rem_wr,
    input wire [2:0] rem_wr_sector,
    input wire [3:0] rem_wr_index,
    input wire [13:0] rem_wr_low,
    input wire [13:0] rem_wr_high
);

// ---------------------------------------------------------------
// Field helper
// ---------------------------------------------------------------
function [13:0] bel_xtime;
    input [13:0] v;
    input wide;
    begin
        if (wide) begin
            bel_xtime = {v[12:0], 1'b0} ^ (v[13] ? `BEL_POLY14 : 14'h0000);
        end else begin
            bel_xtime = {1'b0, v[11:0], 1'b0} ^ (v[12] ? `BEL_POLY13 : 14'h0000);
        end
    end
endfunction

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
wire [9:0] widx_w;
wire coeff_hit_w;
wire pos_hit_w;
wire rem_hit_w;
wire [4:0] coeff_sel_w;
wire [4:0] pos_sel_w;
wire [2:0] rem_sect_w;
wire [3:0] rem_idx_w;
wire [6:0] rem_rd_addr_w;
wire [6:0] rem_wr_addr_w;

assign widx_w = bus_addr[11:2];
assign coeff_hit_w = (widx_w >= `BEL_COEFF_WIDX_FIRST) && (widx_w <= `BEL_COEFF_WIDX_LAST);
assign pos_hit_w = (widx_w >= `BEL_POS_WIDX_FIRST) && (widx_w <= `BEL_POS_WIDX_LAST);
assign coeff_sel_w = bus_addr[6:2] - 5'h0f;
assign pos_sel_w = bus_addr[6:2];
assign rem_sect_w = bus_addr[8:6];
assign rem_idx_w = bus_addr[5:2];
assign rem_hit_w = (bus_addr[11:9] == `BEL_REM_REGION) && (rem_idx_w < `BEL_NUM_REM); // RULE_14
assign rem_rd_addr_w = {rem_sect_w, 3'b000} + {1'b0, rem_sect_w, 2'b00} + {3'b000, rem_idx_w};
assign rem_wr_addr_w = {rem_wr_sector, 3'b000} + {1'b0, rem_wr_sector, 2'b00}
                       + {3'b000, rem_wr_index};

// ---------------------------------------------------------------
// Control registers
// ---------------------------------------------------------------
reg sect1024_q;
reg mask_q;
reg done_q;
reg done_d;
reg busy_q;
reg [13:0] elements_to_test_q;
reg [13:0] elem_q;
reg [4:0] count_q;
reg [13:0] coeff_q [1:`BEL_NUM_COEFF];
reg [13:0] term_q [1:`BEL_NUM_COEFF];
reg [13:0] pos_q [0:`BEL_NUM_COEFF-1];
reg [31:0] reg_rdata_q;
reg rd_rem_q;

wire wr_cfg_w;
wire wr_en_w;
wire wr_dis_w;
wire wr_clr_w;
wire start_w;
wire [13:0] ent_w;
wire [13:0] fmask_w;

assign wr_cfg_w = bus_wr && (bus_addr == `BEL_ADDR_CFG);
assign wr_en_w = bus_wr && (bus_addr == `BEL_ADDR_ENABLE);
assign wr_dis_w = bus_wr && (bus_addr == `BEL_ADDR_DISABLE);
assign wr_clr_w = bus_wr && (bus_addr == `BEL_ADDR_IRQ_STATUS)
                  && bus_wdata[`BEL_DONE_BIT];
assign start_w = wr_en_w; // RULE_04
assign ent_w = bus_wdata[`BEL_ELEMENTS_TO_TEST_MSB:0];
assign fmask_w = sect1024_q ? 14'h3fff : 14'h1fff;

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        sect1024_q <= `BEL_CFG_RST;
        mask_q <= `BEL_MASK_RST;
    end else begin
        if (wr_cfg_w && !busy_q) begin
            sect1024_q <= bus_wdata[`BEL_CFG_SECT1024_BIT]; // RULE_01
        end
        if (bus_wr && (bus_addr == `BEL_ADDR_IRQ_MASK)) begin
            mask_q <= bus_wdata[`BEL_DONE_BIT];
        end
    end
end

// ---------------------------------------------------------------
// Coefficients, per-term multipliers and the evaluation
// ---------------------------------------------------------------
wire [13:0] step_w [1:`BEL_NUM_COEFF];
wire [13:0] prod_w [1:`BEL_NUM_COEFF];
reg [13:0] eval_w;
integer n;

assign step_w[1] = `BEL_ALPHA;

genvar g;
generate
    for (g = 1; g <= `BEL_NUM_COEFF; g = g + 1) begin : g_term
        if (g > 1) begin : g_step
            // Step for term g is alpha^g
            assign step_w[g] = bel_xtime(step_w[g-1], sect1024_q);
        end
        bel_gfmul u_mul (
            .a(term_q[g]),
            .b(step_w[g]),
            .wide(sect1024_q),
            .p(prod_w[g])
        );
        always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                coeff_q[g] <= 14'h0000;
                term_q[g] <= 14'h0000;
            end else begin
                if (bus_wr && coeff_hit_w && (coeff_sel_w == g)) begin
                    coeff_q[g] <= bus_wdata[13:0]; // RULE_02
                end
                if (start_w) begin
                    term_q[g] <= coeff_q[g] & fmask_w; // RULE_03
                end else if (busy_q) begin
                    term_q[g] <= prod_w[g];
                end
            end
        end
    end
endgenerate

// Sigma at the current element, X^0 coefficient fixed at one
always @* begin
    eval_w = `BEL_ONE;
    for (n = 1; n <= `BEL_NUM_COEFF; n = n + 1) begin
        eval_w = eval_w ^ term_q[n];
    end
end

// ---------------------------------------------------------------
// Search sequencer
// ---------------------------------------------------------------
wire root_w;
wire last_w;
wire finish_w;

assign root_w = busy_q && (eval_w == 14'h0000) && (elem_q < elements_to_test_q); // RULE_09
assign last_w = (elem_q + 14'h0001) >= elements_to_test_q; // RULE_06
assign finish_w = busy_q && last_w && !wr_dis_w && !start_w;

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        busy_q <= 1'b0;
        elements_to_test_q <= `BEL_ELEMENTS_TO_TEST_RST;
        elem_q <= 14'h0000;
        count_q <= 5'h00;
    end else if (start_w) begin
        // Restart with the new range, even mid-search
        elements_to_test_q <= ent_w;
        elem_q <= 14'h0000;
        count_q <= 5'h00;
        busy_q <= (ent_w != 14'h0000); // RULE_10
    end else if (wr_dis_w) begin
        busy_q <= 1'b0; // RULE_05
    end else if (busy_q) begin
        elem_q <= elem_q + 14'h0001;
        if (root_w && (count_q < `BEL_MAX_ROOTS)) begin
            count_q <= count_q + 5'h01; // RULE_12
        end
        if (last_w) begin
            busy_q <= 1'b0; // RULE_10
        end
    end
end

generate
    for (g = 0; g < `BEL_NUM_COEFF; g = g + 1) begin : g_pos
        always @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                pos_q[g] <= 14'h0000;
            end else if (start_w) begin
                pos_q[g] <= 14'h0000;
            end else if (root_w && (count_q == g)) begin
                pos_q[g] <= elem_q; // RULE_13
            end
        end
    end
endgenerate

// ---------------------------------------------------------------
// Done flag and interrupt
// ---------------------------------------------------------------
wire zero_start_w;

assign zero_start_w = start_w && (ent_w == 14'h0000);

always @* begin
    done_d = done_q;
    if (wr_clr_w) begin
        done_d = 1'b0;
    end
    if (start_w) begin
        done_d = 1'b0;
    end
    // Completion wins over a same-cycle clear
    if (finish_w || zero_start_w) begin
        done_d = 1'b1; // RULE_11
    end
end

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        done_q <= 1'b0;
        irq <= 1'b0;
    end else begin
        done_q <= done_d;
        irq <= done_d & (bus_wr && (bus_addr == `BEL_ADDR_IRQ_MASK) ?
               bus_wdata[`BEL_DONE_BIT] : mask_q); // RULE_11
    end
end

// ---------------------------------------------------------------
// Remainder store and read path
// ---------------------------------------------------------------
wire [31:0] rem_rdata_w;

bel_rem_mem u_rem (
    .clock(clock),
    .arst_n(arst_n),
    .wr_en(rem_wr),
    .wr_addr(rem_wr_addr_w),
    .wr_low(rem_wr_low),
    .wr_high(rem_wr_high),
    .rd_en(bus_rd && rem_hit_w),
    .rd_addr(rem_rd_addr_w),
    .sector_512(~sect1024_q),
    .rd_data(rem_rdata_w)
);

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata_q <= 32'h00000000;
        rd_rem_q <= 1'b0;
    end else begin
        rd_rem_q <= bus_rd && rem_hit_w;
        reg_rdata_q <= 32'h00000000;
        if (bus_rd) begin
            if (bus_addr == `BEL_ADDR_CFG) begin
                reg_rdata_q <= {31'h00000000, sect1024_q};
            end else if (bus_addr == `BEL_ADDR_STATUS) begin
                reg_rdata_q <= {31'h00000000, busy_q}; // RULE_10
            end else if (bus_addr == `BEL_ADDR_IRQ_STATUS) begin
                reg_rdata_q <= {19'h00000, count_q, 7'h00, done_q}; // RULE_12
            end else if (bus_addr == `BEL_ADDR_IRQ_MASK) begin
                reg_rdata_q <= {31'h00000000, mask_q};
            end else if (coeff_hit_w) begin
                reg_rdata_q <= {18'h00000, coeff_q[coeff_sel_w]};
            end else if (pos_hit_w) begin
                reg_rdata_q <= {18'h00000, pos_q[pos_sel_w]}; // RULE_13
            end
        end
    end
end

assign bus_rdata = rd_rem_q ? rem_rdata_w : reg_rdata_q;

endmodule

// File: inc/bel_map.vh
// Register map, field positions and constants of the BCH error locator
//
// Summary of operation
// RULE_01 - Roots searched over GF(2^13) or GF(2^14)
// RULE_02 - Twenty-four programmable locator coefficient registers
// RULE_03 - Coefficient register i multiplies X^i
// RULE_04 - Any enable register write starts search
// RULE_05 - Disable register write stops the search
// RULE_06 - Software loads elements_to_test; search limited
// RULE_07 - 512-byte sector elements_to_test table values
// RULE_08 - 1024-byte sector elements_to_test table values
// RULE_09 - Roots outside configured range never reported
// RULE_10 - Busy asserted throughout the running search
// RULE_11 - Completion raises interrupt and done bit
// RULE_12 - Error count reports roots found
// RULE_13 - Error positions readable after completion
// RULE_14 - Twelve read-only remainders per sector, eight sectors
// RULE_15 - Remainder bit i is coefficient X^i
// RULE_16 - 512-byte sector: low field bit 13 zero
// RULE_17 - 512-byte sector: word bit 29 zero
// RULE_18 - Low field bits 13:0, high 29:16
`ifndef BEL_MAP_VH
`define BEL_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define BEL_ADDR_CFG 12'h000
`define BEL_ADDR_ENABLE 12'h004
`define BEL_ADDR_DISABLE 12'h008
`define BEL_ADDR_STATUS 12'h00c
`define BEL_ADDR_IRQ_STATUS 12'h010
`define BEL_ADDR_IRQ_MASK 12'h014
`define BEL_COEFF_WIDX_FIRST 10'h010
`define BEL_COEFF_WIDX_LAST 10'h027
`define BEL_POS_WIDX_FIRST 10'h040
`define BEL_POS_WIDX_LAST 10'h057
`define BEL_REM_REGION 3'h1

// ---------------------------------------------------------------
// Field positions and sizes
// ---------------------------------------------------------------
`define BEL_CFG_SECT1024_BIT 0
`define BEL_ELEMENTS_TO_TEST_MSB 13
`define BEL_BUSY_BIT 0
`define BEL_DONE_BIT 0
`define BEL_ERRCNT_LSB 8
`define BEL_ERRCNT_MSB 12
`define BEL_REM_HIGH_LSB 16
`define BEL_NUM_COEFF 24
`define BEL_NUM_REM 4'hc
`define BEL_MAX_ROOTS 5'h18

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define BEL_CFG_RST 1'b0
`define BEL_MASK_RST 1'b0
`define BEL_ELEMENTS_TO_TEST_RST 14'h0000

// ---------------------------------------------------------------
// Field arithmetic
// ---------------------------------------------------------------
`define BEL_POLY13 14'h001b
`define BEL_POLY14 14'h0443
`define BEL_ALPHA 14'h0002
`define BEL_ONE 14'h0001

`endif

// File: rtl/bel_gfmul.v
// General multiplier over GF(2^13) or GF(2^14)
`timescale 1ns/1ns
`include "bel_map.vh"

module bel_gfmul (
    input wire [13:0] a,
    input wire [13:0] b,
    input wire wide,
    output reg [13:0] p
);

integer k;

always @* begin
    p = 14'h0000;
    for (k = 13; k >= 0; k = k - 1) begin
        // Shift and reduce by the field polynomial
        if (wide) begin
            p = {p[12:0], 1'b0} ^ (p[13] ? `BEL_POLY14 : 14'h0000); // RULE_01
        end else begin
            p = {1'b0, p[11:0], 1'b0} ^ (p[12] ? `BEL_POLY13 : 14'h0000); // RULE_01
        end
        if (b[k]) begin
            p = p ^ a;
        end
    end
end

endmodule

// File: rtl/bel_rem_mem.v
// Remainder store: eight sectors by twelve words, registered read
`timescale 1ns/1ns
`include "bel_map.vh"

module bel_rem_mem (
    input wire clock,
    input wire arst_n,
    input wire wr_en,
    input wire [6:0] wr_addr,
    input wire [13:0] wr_low,
    input wire [13:0] wr_high,
    input wire rd_en,
    input wire [6:0] rd_addr,
    input wire sector_512,
    output reg [31:0] rd_data
);

reg [27:0] mem [0:95];
wire [27:0] word_w;

assign word_w = mem[rd_addr];

always @(posedge clock) begin
    if (wr_en) begin
        mem[wr_addr] <= {wr_high, wr_low};
    end
end

always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
        rd_data <= 32'h00000000;
    end else if (rd_en) begin
        // Bit i of each field is coefficient of X^i
        rd_data <= {2'b00, ~sector_512 & word_w[27], word_w[26:14], // RULE_17 RULE_18
                    2'b00, ~sector_512 & word_w[13], word_w[12:0]}; // RULE_15 RULE_16
    end else begin
        rd_data <= 32'h00000000;
    end
end

endmodule

// File: verif/bel_monitor.sv
// Port-level assertions for the BCH error locator
`timescale 1ns/1ns
module bel_mon (
    input wire clock,
    input wire arst_n,
    input wire [11:0] bus_addr,
    input wire [31:0] bus_wdata,
    input wire bus_wr,
    input wire bus_rd,
    input wire [31:0] bus_rdata,
    input wire irq
);
    // ----
    // Sector size shadow
    // ----
    reg wide_q;
    wire rem_rd = bus_rd && bus_addr[11:9] == 3'h1;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            wide_q <= 1'b0;
        else if (bus_wr && bus_addr == 12'h000)
            wide_q <= bus_wdata[0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    a_rdata_idle: assert property (!bus_rd |=> bus_rdata == 32'h0)
        else $error("read data not zero outside read");
    a_rem_pad_zero: assert property (rem_rd |=>
        bus_rdata[31:30] == 2'h0 && bus_rdata[15:14] == 2'h0)
        else $error("remainder pad bits set");
    a_rem_narrow: assert property (rem_rd && !wide_q |=>
        !bus_rdata[29] && !bus_rdata[13])
        else $error("unused remainder bit set");
    a_rem_unused: assert property (rem_rd && bus_addr[5:2] > 4'hb |=>
        bus_rdata == 32'h0)
        else $error("remainder index above 11 not zero");
    a_status_bits: assert property (bus_rd && bus_addr == 12'h00c |=>
        bus_rdata[31:1] == 31'h0)
        else $error("status spare bits set");
    a_irqst_bits: assert property (bus_rd && bus_addr == 12'h010 |=>
        bus_rdata[31:13] == 19'h0 && bus_rdata[7:1] == 7'h0 && bus_rdata[12:8] <= 5'h18)
        else $error("irq status layout wrong");
    a_coeff_width: assert property (bus_rd && bus_addr >= 12'h040 &&
        bus_addr <= 12'h09c |=> bus_rdata[31:14] == 18'h0)
        else $error("coefficient wider than field");
    a_mask_off: assert property (bus_wr && bus_addr == 12'h014 &&
        !bus_wdata[0] |-> ##2 (!irq) [*2])
        else $error("irq high while masked");
    a_start_clear: assert property (bus_wr && bus_addr == 12'h004 &&
        bus_wdata[13:0] > 14'h2 |-> ##2 !irq)
        else $error("irq not cleared by start");
endmodule

bind bel_top bel_mon u_mon (
    .clock(clock),
    .arst_n(arst_n),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_wr(bus_wr),
    .bus_rd(bus_rd),
    .bus_rdata(bus_rdata),
    .irq(irq)
);

// File: verif/tb.sv
// Self-checking bench for the BCH error locator
`timescale 1ns/1ns
module tb;
    reg clock = 1'b0;
    reg arst_n = 1'b0;
    reg [11:0] bus_addr = 12'h000;
    reg [31:0] bus_wdata = 32'h0;
    reg bus_wr = 1'b0;
    reg bus_rd = 1'b0;
    wire [31:0] bus_rdata;
    wire irq;
    reg rem_wr = 1'b0;
    reg [2:0] rem_wr_sector = 3'h0;
    reg [3:0] rem_wr_index = 4'h0;
    reg [13:0] rem_wr_low = 14'h0;
    reg [13:0] rem_wr_high = 14'h0;
    integer n_mismatch = 0;
    integer checked = 0;
    integer n;
    reg [31:0] d;
    reg [75:0] rows [0:9];
    bel_top dut (
        .clock(clock),
        .arst_n(arst_n),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .irq(irq),
        .rem_wr(rem_wr),
        .rem_wr_sector(rem_wr_sector),
        .rem_wr_index(rem_wr_index),
        .rem_wr_low(rem_wr_low),
        .rem_wr_high(rem_wr_high)
    );
    initial begin
        forever #5 clock = ~clock;
    end
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end
    // ----
    // Tasks
    // ----
    task chk(input string s, input [31:0] e, input [31:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch %0s exp %h got %h", s, e, g);
            end
        end
    endtask
    task wrap_up;
        begin
            if (n_mismatch == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task wr(input [11:0] a, input [31:0] v);
        begin
            @(posedge clock);
            bus_wr <= 1'b1;
            bus_addr <= a;
            bus_wdata <= v;
            @(posedge clock);
            bus_wr <= 1'b0;
        end
    endtask
    task rd(input [11:0] a, output [31:0] q);
        begin
            @(posedge clock);
            bus_rd <= 1'b1;
            bus_addr <= a;
            @(posedge clock);
            bus_rd <= 1'b0;
            #1;
            q = bus_rdata;
        end
    endtask
    task rem_put(input [2:0] s, input [3:0] i, input [13:0] lo, input [13:0] hi);
        begin
            @(posedge clock);
            rem_wr <= 1'b1;
            rem_wr_sector <= s;
            rem_wr_index <= i;
            rem_wr_low <= lo;
            rem_wr_high <= hi;
            @(posedge clock);
            rem_wr <= 1'b0;
        end
    endtask
    task tick(input integer k);
        begin
            repeat (k) @(posedge clock);
            #1;
        end
    endtask
    task search(input [13:0] cnt);
        begin
            wr(12'h004, {18'h0, cnt});
            n = 0;
            while (irq !== 1'b1 && n < 20000) begin
                tick(1);
                n = n + 1;
            end
            chk("cycles", {18'h0, cnt}, n);
        end
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        rows[0] = {12'h000, 32'hffff_ffff, 32'h1};
        rows[1] = {12'h040, 32'hffff_ffff, 32'h3fff};
        rows[2] = {12'h09c, 32'h1234, 32'h1234};
        rows[3] = {12'h040, 32'h0, 32'h0};
        rows[4] = {12'h09c, 32'h0, 32'h0};
        rows[5] = {12'h00c, 32'hffff_ffff, 32'h0};
        rows[6] = {12'h018, 32'hffff_ffff, 32'h0};
        rows[7] = {12'h100, 32'hffff, 32'h0};
        rows[8] = {12'h014, 32'h1, 32'h1};
        rows[9] = {12'h000, 32'h0, 32'h0};
        repeat (20) @(posedge clock);
        chk("irq_rst", 32'h0, {31'h0, irq});
        chk("rdata_rst", 32'h0, bus_rdata);
        arst_n <= 1'b1;
        rd(12'h010, d);
        chk("irqst_rst", 32'h0, d);
        for (int i = 0; i < 10; i++) begin
            wr(rows[i][75:64], rows[i][63:32]);
            rd(rows[i][75:64], d);
            chk("row", rows[i][31:0], d);
        end
        rem_put(3'h7, 4'hb, 14'h3fff, 14'h3fff);
        rem_put(3'h0, 4'h0, 14'h0005, 14'h02a0);
        rd(12'h3ec, d);
        chk("rem_narrow", 32'h1fff_1fff, d);
        rd(12'h200, d);
        chk("rem_bits", 32'h02a0_0005, d);
        rd(12'h230, d);
        chk("rem_idx12", 32'h0, d);
        wr(12'h000, 32'h1);
        rd(12'h3ec, d);
        chk("rem_wide", 32'h3fff_3fff, d);
        wr(12'h000, 32'h0);
        // Polynomial 1 + x^3
        wr(12'h048, 32'h1);
        search(14'd4122);
        rd(12'h010, d);
        chk("count13", 32'h101, d);
        rd(12'h100, d);
        chk("pos13", 32'h0, d);
        rd(12'h00c, d);
        chk("idle", 32'h0, d);
        wr(12'h010, 32'h1);
        tick(2);
        chk("irq_w1c", 32'h0, {31'h0, irq});
        wr(12'h000, 32'h1);
        search(14'd8220);
        rd(12'h010, d);
        chk("count14", 32'h201, d);
        rd(12'h104, d);
        chk("pos14", 32'h1555, d);
        wr(12'h004, 32'd100);
        rd(12'h00c, d);
        chk("busy", 32'h1, d);
        wr(12'h008, 32'h0);
        tick(150);
        rd(12'h010, d);
        chk("abort_done", 32'h0, d & 32'h1);
        rd(12'h00c, d);
        chk("abort_busy", 32'h0, d);
        wr(12'h014, 32'h0);
        wr(12'h004, 32'd5);
        tick(10);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd(12'h010, d);
        chk("done_masked", 32'h1, d & 32'h1);
        wr(12'h014, 32'h1);
        tick(2);
        chk("irq_unmask", 32'h1, {31'h0, irq});
        wr(12'h010, 32'h1);
        tick(2);
        chk("irq_clear", 32'h0, {31'h0, irq});
        // Reset in mid-search clears the engine and the coefficients
        wr(12'h004, 32'd50);
        arst_n <= 1'b0;
        tick(2);
        chk("irq_rst2", 32'h0, {31'h0, irq});
        @(posedge clock);
        arst_n <= 1'b1;
        rd(12'h00c, d);
        chk("busy_rst2", 32'h0, d);
        rd(12'h048, d);
        chk("coeff_rst2", 32'h0, d);
        rd(12'h010, d);
        chk("irqst_rst2", 32'h0, d);
        wrap_up;
    end
endmodule
